// ### rtl/asym_params.svh
// Summary of operation
// - A detected stop indication starts constant-distance braking when it is enabled.
// - Without constant-distance braking, stop uses normal deceleration, reverse value when reversing.
// - Slow-approach indication caps speed at approach speed, separate value for reverse.
// - Enable bit 0 allows detection when the right rail is more positive.
// - Enable bit 1 allows detection when the left rail is more positive.
// - Both polarities may be enabled in normal operation; shuttle wants only one.
// - The sensitivity value sets the voltage-difference detection threshold; 8 to 16 advised.
// - Plain shuttle: terminal stop halts, reverses direction and lights, waits, departs.
// - Shuttle without intermediate stops is enabled by shuttle config bit 4.
// - Terminal dwell time is counted in whole seconds from its config value.
// - Slow-approach sections in plain shuttle reduce speed without changing the sequence.
// - Intermediate shuttle: terminals signal slow approach, stop indications halt at intermediates.
// - An intermediate stop lasts while the stop indication stays present.
// - Shuttle with intermediate stops is enabled by shuttle config bit 5.
// - While shuttling, commands set speed only; stops and reversals come from the track.
// - Constant-distance braking is off when both stop-distance and fixed-decel values are zero.
// - Constant-distance braking is suppressed by the shunting or brake-off functions.
`ifndef ASYM_PARAMS_SVH
`define ASYM_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define DWELL_UNIT_NS 1000000000
`define ASYM_FILTER_CYCLES 16

`define REG_ASYM_EN 4'h0
`define REG_DECEL_FWD 4'h1
`define REG_DECEL_REV 4'h2
`define REG_APPR_FWD 4'h3
`define REG_APPR_REV 4'h4
`define REG_THRESH 4'h5
`define REG_SHUTTLE 4'h6
`define REG_DWELL 4'h7
`define REG_FIXED_DECEL 4'h8
`define REG_VAR_DIST 4'h9
`define REG_STATUS 4'ha

`define BIT_EN_RIGHT 0
`define BIT_EN_LEFT 1
`define BIT_SHUTTLE_PLAIN 4
`define BIT_SHUTTLE_INTER 5

`define RST_ASYM_EN 8'h00
`define RST_DECEL 8'h05
`define RST_APPR 8'h20
`define RST_THRESH 8'h0c
`define RST_SHUTTLE 8'h00
`define RST_DWELL 8'h05
`define RST_STOP_PARAM 8'h00

`endif

// ### rtl/asym_pkg.sv
package asym_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_TERM_BRAKE = 2'b10,
    ST_DWELL = 2'b11
  } ctrl_state_t;

  typedef enum logic [1:0] {
    BRK_NORMAL = 2'b00,
    BRK_FIXED = 2'b01,
    BRK_VARIABLE = 2'b10
  } brake_mode_t;

  // Reverse value when reversing, or forward value when going forward or when the reverse one is left at zero
  function automatic logic [7:0] pick_dir(input logic [7:0] fwd, input logic [7:0] rev,
                                          input logic fwd_dir);
    pick_dir = (fwd_dir || rev == 8'h00) ? fwd : rev;
  endfunction

endpackage

// ### rtl/asym_detector.sv
`timescale 1ns/1ns
`include "asym_params.svh"
module asym_detector import asym_pkg::*; #(
  parameter int FILTER_CYCLES = `ASYM_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Track measurement from the rail front end
  input wire logic [7:0] rail_diff_mag,
  input wire logic right_more_pos,
  input wire logic slow_coded,
  // Configuration
  input wire logic [1:0] polarity_en,
  input wire logic [7:0] threshold,
  // Filtered indications
  output logic stop_ind,
  output logic slow_ind
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);

  typedef struct packed {
    logic present;
    logic kind_slow;
    logic [CW-1:0] cnt;
  } det_state_t;

  det_state_t s_r, s_nxt;
  logic raw;

  always_comb begin
    raw = (rail_diff_mag >= threshold) &&
          ((right_more_pos && polarity_en[`BIT_EN_RIGHT]) ||
           (!right_more_pos && polarity_en[`BIT_EN_LEFT]));
    s_nxt = s_r;
    // A change must persist for the filter length before it is believed
    if (raw != s_r.present || (raw && slow_coded != s_r.kind_slow)) begin
      if (s_r.cnt == CW'(FILTER_CYCLES - 1)) begin
        s_nxt.present = raw;
        s_nxt.kind_slow = slow_coded;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end else begin
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stop_ind = s_r.present && !s_r.kind_slow;
  assign slow_ind = s_r.present && s_r.kind_slow;

  chk_ind_needs_raw: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_r.present) |-> $past(raw)) else $error("indication set without detection");
  chk_pol_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (polarity_en == 2'b00) [*2] |-> !$rose(s_r.present))
    else $error("detection with polarities disabled");
endmodule

// ### rtl/asym_track_stop_shuttle_ctrl.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "asym_params.svh"
module asym_track_stop_shuttle_ctrl import asym_pkg::*; #(
  parameter int ONE_SEC_CYCLES = `DWELL_UNIT_NS / `CLK_PERIOD_NS,
  parameter int FILTER_CYCLES = `ASYM_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Track measurement
  input wire logic [7:0] rail_diff_mag,
  input wire logic right_more_pos,
  input wire logic slow_coded,
  // Commands from the command station
  input wire logic [7:0] cmd_speed,
  input wire logic cmd_dir,
  input wire logic shunting_function,
  input wire logic brake_distance_off_function,
  // Motor feedback
  input wire logic loco_at_rest,
  // Motion control
  output logic [7:0] target_speed,
  output logic [7:0] decel_rate,
  output logic [1:0] brake_mode,
  output logic cbd_stop_req,
  output logic drive_dir,
  output logic lights_fwd,
  output logic lights_rev
);
  localparam int PW = $clog2(ONE_SEC_CYCLES + 1);

  typedef struct packed {
    logic [7:0] asym_detect_enable_cfg;
    logic [7:0] normal_decel_fwd;
    logic [7:0] normal_decel_rev;
    logic [7:0] approach_speed_fwd;
    logic [7:0] approach_speed_rev;
    logic [7:0] asym_threshold_sensitivity;
    logic [7:0] shuttle_and_aux_cfg;
    logic [7:0] terminal_dwell_seconds;
    logic [7:0] fixed_stop_decel;
    logic [7:0] variable_stop_distance;
    logic [7:0] rdata;
    ctrl_state_t state;
    logic dir;
    logic armed;
    logic [7:0] sec_left;
    logic [PW-1:0] pre;
    logic [7:0] speed;
    logic [7:0] decel;
    brake_mode_t mode;
    logic cbd_req;
    logic dir_out;
  } ctrl_reg_t;

  ctrl_reg_t s_r, s_nxt;
  logic stop_ind, slow_ind;
  logic shuttle_plain, shuttle_inter, shuttle;
  logic cbd_on, cur_dir, terminal_hit, braking;
  logic [7:0] approach;
  brake_mode_t cbd_mode;

  asym_detector #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_det (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rail_diff_mag(rail_diff_mag),
    .right_more_pos(right_more_pos),
    .slow_coded(slow_coded),
    .polarity_en(s_r.asym_detect_enable_cfg[1:0]),
    .threshold(s_r.asym_threshold_sensitivity),
    .stop_ind(stop_ind),
    .slow_ind(slow_ind)
  );

  always_comb begin
    // Plain shuttle takes precedence if both enables are set
    shuttle_plain = s_r.shuttle_and_aux_cfg[`BIT_SHUTTLE_PLAIN];
    shuttle_inter = s_r.shuttle_and_aux_cfg[`BIT_SHUTTLE_INTER] && !shuttle_plain;
    shuttle = shuttle_plain || shuttle_inter;
    cbd_on = (s_r.variable_stop_distance != 8'h00 || s_r.fixed_stop_decel != 8'h00) &&
             !shunting_function && !brake_distance_off_function;
    cbd_mode = (s_r.variable_stop_distance != 8'h00) ? BRK_VARIABLE : BRK_FIXED;
    cur_dir = shuttle ? s_r.dir : cmd_dir;
    approach = pick_dir(s_r.approach_speed_fwd, s_r.approach_speed_rev, cur_dir);
    // Terminal marker: stop in plain shuttle, slow approach with intermediate stops
    terminal_hit = s_r.armed && ((shuttle_plain && stop_ind) ||
                                 (shuttle_inter && slow_ind));
    braking = s_r.state != ST_RUN;

    s_nxt = s_r;
    s_nxt.rdata = 8'h00;

    if (reg_wr) begin
      case (reg_addr)
        `REG_ASYM_EN: s_nxt.asym_detect_enable_cfg = reg_wdata;
        `REG_DECEL_FWD: s_nxt.normal_decel_fwd = reg_wdata;
        `REG_DECEL_REV: s_nxt.normal_decel_rev = reg_wdata;
        `REG_APPR_FWD: s_nxt.approach_speed_fwd = reg_wdata;
        `REG_APPR_REV: s_nxt.approach_speed_rev = reg_wdata;
        `REG_THRESH: s_nxt.asym_threshold_sensitivity = reg_wdata;
        `REG_SHUTTLE: s_nxt.shuttle_and_aux_cfg = reg_wdata;
        `REG_DWELL: s_nxt.terminal_dwell_seconds = reg_wdata;
        `REG_FIXED_DECEL: s_nxt.fixed_stop_decel = reg_wdata;
        `REG_VAR_DIST: s_nxt.variable_stop_distance = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_ASYM_EN: s_nxt.rdata = s_r.asym_detect_enable_cfg;
        `REG_DECEL_FWD: s_nxt.rdata = s_r.normal_decel_fwd;
        `REG_DECEL_REV: s_nxt.rdata = s_r.normal_decel_rev;
        `REG_APPR_FWD: s_nxt.rdata = s_r.approach_speed_fwd;
        `REG_APPR_REV: s_nxt.rdata = s_r.approach_speed_rev;
        `REG_THRESH: s_nxt.rdata = s_r.asym_threshold_sensitivity;
        `REG_SHUTTLE: s_nxt.rdata = s_r.shuttle_and_aux_cfg;
        `REG_DWELL: s_nxt.rdata = s_r.terminal_dwell_seconds;
        `REG_FIXED_DECEL: s_nxt.rdata = s_r.fixed_stop_decel;
        `REG_VAR_DIST: s_nxt.rdata = s_r.variable_stop_distance;
        `REG_STATUS: s_nxt.rdata = {1'b0, s_r.armed, s_r.state, s_r.dir_out, braking,
                                    slow_ind, stop_ind};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Outside shuttle the direction follows the command, so a later switch
    // into shuttle starts in the direction currently driven
    if (!shuttle) begin
      s_nxt.dir = cmd_dir;
    end

    case (s_r.state)
      ST_RUN: begin
        if (!stop_ind && !slow_ind) begin
          s_nxt.armed = 1'b1;
        end
        if (shuttle && terminal_hit) begin
          s_nxt.state = ST_TERM_BRAKE;
          s_nxt.armed = 1'b0;
        end else if (stop_ind && !shuttle_plain) begin
          s_nxt.state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!stop_ind) begin
          s_nxt.state = ST_RUN;
        end
      end
      ST_TERM_BRAKE: begin
        if (loco_at_rest) begin
          s_nxt.state = ST_DWELL;
          s_nxt.dir = !s_r.dir;
          s_nxt.sec_left = s_r.terminal_dwell_seconds;
          s_nxt.pre = '0;
        end
      end
      ST_DWELL: begin
        if (s_r.sec_left == 8'h00) begin
          s_nxt.state = ST_RUN;
        end else if (s_r.pre == PW'(ONE_SEC_CYCLES - 1)) begin
          s_nxt.pre = '0;
          s_nxt.sec_left = s_r.sec_left - 8'h01;
        end else begin
          s_nxt.pre = s_r.pre + PW'(1);
        end
      end
      default: s_nxt.state = ST_RUN;
    endcase

    // Motion outputs, registered
    if (braking) begin
      s_nxt.speed = 8'h00;
    end else if (slow_ind && cmd_speed > approach) begin
      s_nxt.speed = approach;
    end else begin
      s_nxt.speed = cmd_speed;
    end
    if (cbd_on) begin
      s_nxt.mode = cbd_mode;
      s_nxt.decel = (cbd_mode == BRK_VARIABLE) ? s_r.variable_stop_distance
                                                : s_r.fixed_stop_decel;
    end else begin
      s_nxt.mode = BRK_NORMAL;
      s_nxt.decel = pick_dir(s_r.normal_decel_fwd, s_r.normal_decel_rev, cur_dir);
    end
    s_nxt.cbd_req = braking && s_r.state != ST_DWELL && cbd_on;
    s_nxt.dir_out = (s_r.state == ST_DWELL) ? s_r.dir : cur_dir;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.asym_detect_enable_cfg <= `RST_ASYM_EN;
      s_r.normal_decel_fwd <= `RST_DECEL;
      s_r.normal_decel_rev <= `RST_STOP_PARAM;
      s_r.approach_speed_fwd <= `RST_APPR;
      s_r.approach_speed_rev <= `RST_STOP_PARAM;
      s_r.asym_threshold_sensitivity <= `RST_THRESH;
      s_r.shuttle_and_aux_cfg <= `RST_SHUTTLE;
      s_r.terminal_dwell_seconds <= `RST_DWELL;
      s_r.fixed_stop_decel <= `RST_STOP_PARAM;
      s_r.variable_stop_distance <= `RST_STOP_PARAM;
      s_r.state <= ST_RUN;
      s_r.mode <= BRK_NORMAL;
      s_r.dir <= 1'b1;
      s_r.dir_out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign target_speed = s_r.speed;
  assign decel_rate = s_r.decel;
  assign brake_mode = s_r.mode;
  assign cbd_stop_req = s_r.cbd_req;
  assign drive_dir = s_r.dir_out;
  assign lights_fwd = s_r.dir_out;
  assign lights_rev = !s_r.dir_out;

  sequence seq_halted;
    s_r.state == ST_TERM_BRAKE && loco_at_rest;
  endsequence

  sequence seq_dwell_entered;
    s_r.state == ST_DWELL && s_r.dir != $past(s_r.dir);
  endsequence

  sequence seq_dwell_done;
    s_r.state == ST_DWELL && s_r.sec_left == 8'h00;
  endsequence

  chk_halt_reverse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_halted |=> seq_dwell_entered)
    else $error("terminal halt did not reverse");
  chk_dwell_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.state == ST_DWELL |-> ##1 target_speed == 8'h00 ##0 drive_dir == $past(s_r.dir))
    else $error("speed or direction wrong in dwell");
  chk_dwell_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_DWELL && s_r.sec_left != 8'h00) |=> s_r.state == ST_DWELL)
    else $error("dwell ended early");
  chk_stop_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_STOP && stop_ind) |=> s_r.state == ST_STOP)
    else $error("intermediate stop released early");
  chk_plain_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && shuttle_plain && s_r.armed && stop_ind)
    |=> s_r.state == ST_TERM_BRAKE) else $error("plain shuttle missed terminal");
  chk_inter_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && shuttle_inter && stop_ind && !(s_r.armed && slow_ind))
    |=> s_r.state == ST_STOP) else $error("intermediate stop missed");
  chk_cbd_inhibit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (shunting_function || brake_distance_off_function) |=>
      brake_mode == BRK_NORMAL && !cbd_stop_req)
    else $error("constant distance braking not suppressed");
  chk_cbd_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.fixed_stop_decel == 8'h00 && s_r.variable_stop_distance == 8'h00)
    |=> brake_mode == BRK_NORMAL) else $error("braking mode with zero parameters");
  chk_stop_brake: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_STOP && cbd_on) |=> cbd_stop_req) else $error("no braking request");
  chk_slow_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && slow_ind) |=> target_speed <= $past(approach))
    else $error("approach speed exceeded");
  chk_cmd_no_reverse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (shuttle && s_r.state == ST_RUN) |=> s_r.dir == $past(s_r.dir))
    else $error("direction changed outside terminal");
  chk_slow_sequence: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && shuttle_plain && slow_ind) |=> s_r.state == ST_RUN)
    else $error("slow approach altered shuttle sequence");
  chk_term_speed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.state == ST_TERM_BRAKE |=> target_speed == 8'h00)
    else $error("speed not zero while halting at terminal");
  chk_dwell_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_halted |=> s_r.sec_left == $past(s_r.terminal_dwell_seconds))
    else $error("dwell count not loaded");
  chk_dwell_resume: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_dwell_done |=> s_r.state == ST_RUN)
    else $error("no departure after dwell");
  chk_stop_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_STOP && !stop_ind) |=> s_r.state == ST_RUN)
    else $error("stop kept after indication cleared");
  chk_stop_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && !shuttle && stop_ind) |=> s_r.state == ST_STOP)
    else $error("stop indication ignored");
  chk_normal_decel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cbd_on && cur_dir) |=> brake_mode == BRK_NORMAL &&
      decel_rate == $past(s_r.normal_decel_fwd))
    else $error("normal deceleration not applied");
  chk_var_priority: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cbd_on && s_r.variable_stop_distance != 8'h00) |=> brake_mode == BRK_VARIABLE &&
      decel_rate == $past(s_r.variable_stop_distance))
    else $error("variable stop distance not selected");
  chk_fixed_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cbd_on && s_r.variable_stop_distance == 8'h00) |=> brake_mode == BRK_FIXED &&
      decel_rate == $past(s_r.fixed_stop_decel))
    else $error("fixed deceleration not selected");
  chk_run_speed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.state == ST_RUN && !slow_ind) |=> target_speed == $past(cmd_speed))
    else $error("commanded speed not followed");
  chk_dir_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !shuttle |=> s_r.dir == $past(cmd_dir))
    else $error("direction does not follow command");
endmodule

// ### tb/track_sections.sv
`timescale 1ns/1ns
module track_sections (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Scenario control
  input wire logic [1:0] section,
  input wire logic left_pos,
  input wire logic [7:0] strength,
  input wire logic [3:0] rest_delay,
  // Decoder side
  input wire logic [7:0] target_speed,
  output logic [7:0] rail_diff_mag,
  output logic right_more_pos,
  output logic slow_coded,
  output logic loco_at_rest
);
  logic [3:0] still_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_diff_mag <= 8'h00;
      right_more_pos <= 1'b0;
      slow_coded <= 1'b0;
      still_r <= 4'h0;
      loco_at_rest <= 1'b0;
    end else begin
      // Plain section: no difference, so the polarity and code lines mean nothing
      if (section == 2'h0) begin
        rail_diff_mag <= 8'h00;
        right_more_pos <= ~right_more_pos;
        slow_coded <= ~slow_coded;
      end else begin
        rail_diff_mag <= strength;
        right_more_pos <= !left_pos;
        slow_coded <= (section == 2'h2);
      end
      // Standstill only after the setpoint has stayed zero for rest_delay cycles
      if (target_speed != 8'h00) begin
        still_r <= 4'h0;
      end else if (still_r != rest_delay) begin
        still_r <= still_r + 4'h1;
      end
      loco_at_rest <= (target_speed == 8'h00) && (still_r == rest_delay);
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "asym_params.svh"
module testbench import asym_pkg::*; ();
  localparam int OSC = 20;
  localparam int FLT = 4;
  localparam int SETTLE = FLT + 6;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rail_diff_mag;
  logic right_more_pos;
  logic slow_coded;
  logic loco_at_rest;
  logic [7:0] cmd_speed = 8'h60;
  logic cmd_dir = 1'b1;
  logic shunting_function = 1'b0;
  logic brake_distance_off_function = 1'b0;
  logic [1:0] section = 2'h0;
  logic left_pos = 1'b0;
  logic [7:0] strength = 8'h20;
  logic [3:0] rest_delay = 4'h3;
  logic [7:0] target_speed;
  logic [7:0] decel_rate;
  logic [1:0] brake_mode;
  logic cbd_stop_req;
  logic drive_dir;
  logic lights_fwd;
  logic lights_rev;
  int miscompares = 0;
  int check_count = 0;

  asym_track_stop_shuttle_ctrl #(.ONE_SEC_CYCLES(OSC), .FILTER_CYCLES(FLT)) uut (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rail_diff_mag,
    .right_more_pos, .slow_coded, .cmd_speed, .cmd_dir, .shunting_function,
    .brake_distance_off_function, .loco_at_rest, .target_speed, .decel_rate, .brake_mode,
    .cbd_stop_req, .drive_dir, .lights_fwd, .lights_rev
  );
  track_sections model (
    .ref_clk, .rst_n, .section, .left_pos, .strength, .rest_delay, .target_speed,
    .rail_diff_mag, .right_more_pos, .slow_coded, .loco_at_rest
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic track(input logic [1:0] sec);
    @(posedge ref_clk);
    section <= sec;
    repeat (SETTLE) @(posedge ref_clk);
    #1;
  endtask

  // Waits for motion to resume (go) or for drive_dir to reach d
  task automatic wait_for(input logic go, input logic d, output int n);
    n = 0;
    while ((go ? target_speed === 8'h00 : drive_dir !== d) && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic scene(input logic [1:0] sec, input logic lp, input logic [7:0] s,
                       input logic dir, input logic [7:0] spd, input logic sh,
                       input logic bo, output logic [7:0] tsp, output logic [15:0] bw);
    @(posedge ref_clk);
    left_pos <= lp;
    strength <= s;
    cmd_dir <= dir;
    cmd_speed <= spd;
    shunting_function <= sh;
    brake_distance_off_function <= bo;
    track(sec);
    tsp = target_speed;
    bw = {cbd_stop_req, 5'h00, brake_mode, decel_rate};
    track(2'h0);
  endtask

  task automatic t_regs();
    logic [7:0] rst_vals [10] = '{8'h00, 8'h05, 8'h00, 8'h20, 8'h00, 8'h0c, 8'h00, 8'h05,
                                  8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(4'(i), d);
      check(d, rst_vals[i]);
    end
    @(posedge ref_clk);
    #1;
    check(reg_rdata, 8'h00);
    rd(4'hb, d);
    check(d, 8'h00);
    wr(`REG_STATUS, 8'hff);
    rd(`REG_STATUS, d);
    check(d & 8'h3f, 8'h08);
  endtask

  task automatic t_detect();
    logic [7:0] t;
    logic [15:0] b;
    wr(`REG_ASYM_EN, 8'h01);
    scene(2'h1, 1'b0, 8'h0c, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h00);
    scene(2'h1, 1'b1, 8'h40, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h60);
    scene(2'h1, 1'b0, 8'h0b, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h60);
    wr(`REG_THRESH, 8'h09);
    scene(2'h1, 1'b0, 8'h0b, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h00);
    wr(`REG_THRESH, 8'h0c);
    wr(`REG_ASYM_EN, 8'h02);
    scene(2'h1, 1'b1, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h00);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h60);
    wr(`REG_ASYM_EN, 8'h03);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h00);
    scene(2'h1, 1'b1, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h00);
  endtask

  task automatic t_brake();
    logic [7:0] t;
    logic [15:0] b;
    wr(`REG_ASYM_EN, 8'h01);
    wr(`REG_DECEL_REV, 8'h09);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(b, 16'h0005);
    scene(2'h1, 1'b0, 8'h20, 1'b0, 8'h60, 1'b0, 1'b0, t, b);
    check(b, 16'h0009);
    wr(`REG_FIXED_DECEL, 8'h11);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(b, 16'h8111);
    wr(`REG_VAR_DIST, 8'h07);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(b, 16'h8207);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b1, 1'b0, t, b);
    check(b, 16'h0005);
    scene(2'h1, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b1, t, b);
    check(b, 16'h0005);
    wr(`REG_APPR_REV, 8'h14);
    scene(2'h2, 1'b0, 8'h20, 1'b1, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h20);
    scene(2'h2, 1'b0, 8'h20, 1'b0, 8'h60, 1'b0, 1'b0, t, b);
    check(t, 8'h14);
    scene(2'h2, 1'b0, 8'h20, 1'b1, 8'h10, 1'b0, 1'b0, t, b);
    check(t, 8'h10);
    wr(`REG_APPR_REV, 8'h00);
  endtask

  task automatic t_shuttle();
    int n;
    wr(`REG_SHUTTLE, 8'h10);
    wr(`REG_DWELL, 8'h02);
    @(posedge ref_clk);
    cmd_speed <= 8'h40;
    rest_delay <= 4'hc;
    track(2'h0);
    track(2'h1);
    check({target_speed, 7'h00, cbd_stop_req}, 16'h0001);
    wait_for(1'b0, 1'b0, n);
    check({n < 300, lights_fwd, lights_rev}, 3'b101);
    wait_for(1'b1, 1'b0, n);
    check(n >= 2 * OSC - 2 && n <= 2 * OSC + 4, 1'b1);
    check({target_speed, drive_dir}, 9'h080);
    @(posedge ref_clk);
    cmd_speed <= 8'h30;
    track(2'h2);
    check({target_speed, drive_dir}, 9'h040);
    track(2'h0);
    check({target_speed, drive_dir}, 9'h060);
    track(2'h1);
    wait_for(1'b0, 1'b1, n);
    check(n < 300, 1'b1);
    wait_for(1'b1, 1'b0, n);
    wr(`REG_SHUTTLE, 8'h20);
    track(2'h0);
    track(2'h1);
    check({target_speed, drive_dir}, 9'h001);
    repeat (60) @(posedge ref_clk);
    #1;
    check({target_speed, drive_dir}, 9'h001);
    track(2'h0);
    check({target_speed, drive_dir}, 9'h061);
    track(2'h2);
    wait_for(1'b0, 1'b0, n);
    check(n < 300, 1'b1);
    wait_for(1'b1, 1'b0, n);
    check(target_speed, 8'h20);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    check({target_speed, brake_mode, cbd_stop_req, drive_dir, lights_fwd, lights_rev},
          16'h0006);
    repeat (9) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_detect();
    t_brake();
    t_shuttle();
    finish_test();
  end

  // Whole run takes about 800 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule
